// [logic/udsc_regs.svh]
// register offsets, field positions and reset values of the usb device state control block
`ifndef UDSC_REGS_SVH
`define UDSC_REGS_SVH
`define UDSC_OFF_FRAME 8'h00
`define UDSC_OFF_GLB 8'h04
`define UDSC_OFF_FADDR 8'h08
`define UDSC_OFF_IEN 8'h10
`define UDSC_OFF_IDIS 8'h14
`define UDSC_OFF_IMASK 8'h18
`define UDSC_OFF_ISTAT 8'h1c
`define UDSC_OFF_ICLR 8'h20
`define UDSC_OFF_EPRST 8'h28
`define UDSC_OFF_CSR_BASE 8'h30
`define UDSC_OFF_FDR_BASE 8'h50
`define UDSC_OFF_TXVC 8'h74
`define UDSC_EP_COUNT 3'h6
`define UDSC_FADDR_RESET 32'h0000_0100
`define UDSC_IMASK_RESET 14'h1200
`define UDSC_INT_W 14
`define UDSC_BIT_SUSP 8
`define UDSC_BIT_RSM 9
`define UDSC_BIT_EXTRSM 10
`define UDSC_BIT_SOF 11
`define UDSC_BIT_BUS_RESET_DONE_FLAG 12
`define UDSC_BIT_WAKEUP 13
`define UDSC_GLB_ADDRESS_STATE_ENABLE 0
`define UDSC_GLB_CONFG 1
`define UDSC_GLB_RSMINPR 3
`define UDSC_FADDR_FEN 8
`define UDSC_FEN_RESET 1'b1
`define UDSC_TXVC_TRANSCEIVER_DISABLE_BIT 8
`define UDSC_TXVC_PULLUP_ON_BIT 9
`define UDSC_CSR_ENDPOINT_ENABLE_BIT 15
`define UDSC_FRAME_GOOD_BIT 17
`define UDSC_FRAME_ERROR_BIT 16
`endif

// [logic/udsc_pkg.sv]
// types of the usb device state control block
package udsc_pkg;
   typedef enum logic [2:0] {
      UDSC_ST_ATTACHED,
      UDSC_ST_POWERED,
      UDSC_ST_DEFAULT,
      UDSC_ST_ADDRESS,
      UDSC_ST_CONFIGURED,
      UDSC_ST_SUSPENDED
   } udsc_state_e;
endpackage

// [logic/udsc_resume_det.sv]
// asynchronous resume catcher with two-flop synchroniser toward clk
`timescale 1ns/1ns
module udsc_resume_det (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic arm,
   input wire logic bus_activity,
   input wire logic ack,
   output logic resume_seen
);
   logic caught_r;
   logic sync1_r;
   logic sync2_r;
   // latched on the bus edge itself so no clock is needed while suspended
   always_ff @(posedge bus_activity or posedge ack or negedge rst_n) begin
      if (!rst_n) begin
         caught_r <= 1'b0;
      end else if (ack) begin
         caught_r <= 1'b0;
      end else begin
         caught_r <= arm;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= caught_r;
         sync2_r <= sync1_r;
      end
   end
   assign resume_seen = sync2_r;
endmodule

// [logic/udsc_top.sv]
// usb device port state control and register map
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "udsc_regs.svh"
module udsc_top
   import udsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic bus_idle_timeout,
   input wire logic bus_reset_end,
   input wire logic bus_activity,
   input wire logic sof_start,
   input wire logic sof_end,
   input wire logic sof_error,
   input wire logic [10:0] sof_frame,
   input wire logic ext_resume,
   input wire logic [5:0] ep_event,
   input wire logic [31:0] ep_fifo_rdata,
   output logic irq,
   output logic pullup_on,
   output logic transceiver_off,
   output logic function_enabled,
   output logic [6:0] device_address,
   output logic [2:0] device_state,
   output logic [5:0] ep_enabled
);
   typedef struct packed {
      logic [31:0] rdata;
      logic [10:0] frame;
      logic frame_good_bit;
      logic frame_error_bit;
      logic faddr_en;
      logic confg;
      logic [6:0] fadd;
      logic function_enable_bit;
      logic [13:0] mask;
      logic [13:0] stat;
      logic [5:0] ep_rst;
      logic [5:0][15:0] csr;
      logic transceiver_disable_bit;
      logic pullup_on_bit;
      logic irq;
      udsc_state_e st;
   } udsc_state_s;

   udsc_state_s s_r;
   udsc_state_s s_nxt;
   logic resume_seen;
   logic resume_seen_d_r;
   logic resume_ack;

   // endpoint index for a word address inside a window of six words
   function automatic logic [3:0] udsc_ep_index(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      if (a >= base && d[7:2] < {3'h0, `UDSC_EP_COUNT} && d[1:0] == 2'h0) begin
         udsc_ep_index = {1'b1, d[4:2]};
      end else begin
         udsc_ep_index = 4'h0;
      end
   endfunction

   udsc_resume_det u_resume (
      .clk(clk),
      .rst_n(rst_n),
      .arm(s_r.st == UDSC_ST_SUSPENDED),
      .bus_activity(bus_activity),
      .ack(resume_ack),
      .resume_seen(resume_seen)
   );

   // catcher is released once the synchronised copy has been seen
   assign resume_ack = resume_seen;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resume_seen_d_r <= 1'b0;
      end else begin
         resume_seen_d_r <= resume_seen;
      end
   end

   always_comb begin
      logic [3:0] csr_i;
      logic [3:0] fdr_i;
      logic [13:0] set_ev;
      csr_i = udsc_ep_index(reg_addr, `UDSC_OFF_CSR_BASE);
      fdr_i = udsc_ep_index(reg_addr, `UDSC_OFF_FDR_BASE);
      s_nxt = s_r;
      s_nxt.rdata = 32'h0;
      set_ev = 14'h0;
      // frame count latched at end of sof; ok/err cleared at sof pid
      if (sof_start) begin
         s_nxt.frame_good_bit = 1'b0;
         s_nxt.frame_error_bit = 1'b0;
      end
      if (sof_end) begin
         s_nxt.frame = sof_frame;
         s_nxt.frame_good_bit = !sof_error;
         s_nxt.frame_error_bit = sof_error;
      end
      // function endpoints only report traffic while enabled
      if (s_r.function_enable_bit) begin
         set_ev[5:0] = ep_event;
      end
      set_ev[`UDSC_BIT_SOF] = sof_start;
      set_ev[`UDSC_BIT_SUSP] = bus_idle_timeout && s_r.st != UDSC_ST_SUSPENDED;
      set_ev[`UDSC_BIT_RSM] = bus_activity && s_r.st == UDSC_ST_SUSPENDED;
      set_ev[`UDSC_BIT_EXTRSM] = ext_resume;
      set_ev[`UDSC_BIT_WAKEUP] = resume_seen && !resume_seen_d_r;
      set_ev[`UDSC_BIT_BUS_RESET_DONE_FLAG] = bus_reset_end;

      if (reg_wr) begin
         if (reg_addr == `UDSC_OFF_GLB) begin
            if (reg_wdata[`UDSC_GLB_ADDRESS_STATE_ENABLE]) begin
               s_nxt.faddr_en = 1'b1;
            end
            s_nxt.confg = reg_wdata[`UDSC_GLB_CONFG];
         end else if (reg_addr == `UDSC_OFF_FADDR) begin
            s_nxt.fadd = reg_wdata[6:0];
            s_nxt.function_enable_bit = reg_wdata[`UDSC_FADDR_FEN];
         end else if (reg_addr == `UDSC_OFF_IEN) begin
            s_nxt.mask = s_r.mask | reg_wdata[13:0];
         end else if (reg_addr == `UDSC_OFF_IDIS) begin
            s_nxt.mask = s_r.mask & ~reg_wdata[13:0];
         end else if (reg_addr == `UDSC_OFF_ICLR) begin
            // clear loses to a same-cycle event
            s_nxt.stat = s_r.stat & ~reg_wdata[13:0];
            if (reg_wdata[`UDSC_BIT_SUSP] && s_r.stat[`UDSC_BIT_SUSP]) begin
               s_nxt.st = UDSC_ST_SUSPENDED;
            end
         end else if (reg_addr == `UDSC_OFF_EPRST) begin
            s_nxt.ep_rst = reg_wdata[5:0];
         end else if (reg_addr == `UDSC_OFF_TXVC) begin
            s_nxt.transceiver_disable_bit = reg_wdata[`UDSC_TXVC_TRANSCEIVER_DISABLE_BIT];
            s_nxt.pullup_on_bit = reg_wdata[`UDSC_TXVC_PULLUP_ON_BIT];
         end else if (csr_i[3]) begin
            s_nxt.csr[csr_i[2:0]] = reg_wdata[15:0];
         end
      end
      s_nxt.stat = s_nxt.stat | set_ev;

      if (reg_rd) begin
         if (reg_addr == `UDSC_OFF_FRAME) begin
            s_nxt.rdata[10:0] = s_r.frame;
            s_nxt.rdata[`UDSC_FRAME_GOOD_BIT] = s_r.frame_good_bit;
            s_nxt.rdata[`UDSC_FRAME_ERROR_BIT] = s_r.frame_error_bit;
         end else if (reg_addr == `UDSC_OFF_GLB) begin
            s_nxt.rdata[`UDSC_GLB_ADDRESS_STATE_ENABLE] = s_r.faddr_en;
            s_nxt.rdata[`UDSC_GLB_CONFG] = s_r.confg;
            s_nxt.rdata[`UDSC_GLB_RSMINPR] = s_r.stat[`UDSC_BIT_EXTRSM];
         end else if (reg_addr == `UDSC_OFF_FADDR) begin
            s_nxt.rdata[6:0] = s_r.fadd;
            s_nxt.rdata[`UDSC_FADDR_FEN] = s_r.function_enable_bit;
         end else if (reg_addr == `UDSC_OFF_IMASK) begin
            s_nxt.rdata[13:0] = s_r.mask;
         end else if (reg_addr == `UDSC_OFF_ISTAT) begin
            s_nxt.rdata[13:0] = s_r.stat;
         end else if (reg_addr == `UDSC_OFF_EPRST) begin
            s_nxt.rdata[5:0] = s_r.ep_rst;
         end else if (reg_addr == `UDSC_OFF_TXVC) begin
            s_nxt.rdata[`UDSC_TXVC_TRANSCEIVER_DISABLE_BIT] = s_r.transceiver_disable_bit;
            s_nxt.rdata[`UDSC_TXVC_PULLUP_ON_BIT] = s_r.pullup_on_bit;
         end else if (csr_i[3]) begin
            s_nxt.rdata[15:0] = s_r.csr[csr_i[2:0]];
         end else if (fdr_i[3]) begin
            s_nxt.rdata = ep_fifo_rdata;
         end
      end

      // device state tracking
      case (s_r.st)
         UDSC_ST_ATTACHED: begin
            if (s_nxt.pullup_on_bit) begin
               s_nxt.st = UDSC_ST_POWERED;
            end
         end
         UDSC_ST_SUSPENDED: begin
            if (resume_seen || bus_activity) begin
               // host resume goes to configured if confg is set, else to address if faddr_en is set, else to default
               if (s_r.confg) begin
                  s_nxt.st = UDSC_ST_CONFIGURED;
               end else if (s_r.faddr_en) begin
                  s_nxt.st = UDSC_ST_ADDRESS;
               end else begin
                  s_nxt.st = UDSC_ST_DEFAULT;
               end
            end
         end
         default: begin
            if (s_nxt.confg && s_nxt.faddr_en) begin
               s_nxt.st = s_nxt.st == UDSC_ST_SUSPENDED ? UDSC_ST_SUSPENDED : UDSC_ST_CONFIGURED;
            end else if (s_nxt.faddr_en && s_nxt.st != UDSC_ST_SUSPENDED && s_r.st != UDSC_ST_POWERED) begin
               s_nxt.st = UDSC_ST_ADDRESS;
            end
         end
      endcase
      if (!s_nxt.pullup_on_bit) begin
         s_nxt.st = UDSC_ST_ATTACHED;
      end

      // bus reset end overrides same-cycle writes to mask, csr, address and config; state goes to default only with pull-up on
      if (bus_reset_end) begin
         s_nxt.mask = `UDSC_IMASK_RESET;
         s_nxt.csr = '0;
         s_nxt.faddr_en = 1'b0;
         s_nxt.confg = 1'b0;
         s_nxt.fadd = 7'h0;
         if (s_nxt.pullup_on_bit) begin
            s_nxt.st = UDSC_ST_DEFAULT;
         end
      end

      // bus reset done cannot be masked
      s_nxt.irq = |(s_nxt.stat & (s_nxt.mask | (14'h1 << `UDSC_BIT_BUS_RESET_DONE_FLAG)));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.function_enable_bit <= `UDSC_FEN_RESET;
         s_r.mask <= `UDSC_IMASK_RESET;
         s_r.st <= UDSC_ST_ATTACHED;
         // status left cleared for determinism; software must not rely on it
         s_r.stat <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      reg_rdata = s_r.rdata;
      irq = s_r.irq;
      pullup_on = s_r.pullup_on_bit;
      transceiver_off = s_r.transceiver_disable_bit;
      function_enabled = s_r.function_enable_bit;
      device_address = s_r.fadd;
      device_state = s_r.st;
   end

   // enable bit of each endpoint control word
   for (genvar g = 0; g < `UDSC_EP_COUNT; g++) begin : g_ep_en
      assign ep_enabled[g] = s_r.csr[g][`UDSC_CSR_ENDPOINT_ENABLE_BIT];
   end

   a_busres_irq: assert property (@(posedge clk) disable iff (!rst_n)
      bus_reset_end |=> irq && s_r.stat[`UDSC_BIT_BUS_RESET_DONE_FLAG]) else $error("bus reset end gave no irq");
   a_busres_mask: assert property (@(posedge clk) disable iff (!rst_n)
      bus_reset_end |=> s_r.mask == `UDSC_IMASK_RESET && s_r.csr == '0) else $error("mask not restored");
   sequence set_susp_seq;
      bus_idle_timeout && s_r.st != UDSC_ST_SUSPENDED;
   endsequence
   a_susp_flag: assert property (@(posedge clk) disable iff (!rst_n)
      set_susp_seq |=> s_r.stat[`UDSC_BIT_SUSP]) else $error("suspend flag not set");
   a_txv_ctrl: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == `UDSC_OFF_TXVC |=> transceiver_off == $past(reg_wdata[`UDSC_TXVC_TRANSCEIVER_DISABLE_BIT]))
      else $error("transceiver bit not applied");
   a_wake_flag: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(resume_seen) |=> s_r.stat[`UDSC_BIT_WAKEUP]) else $error("wakeup flag not set");
   a_fen_gate: assert property (@(posedge clk) disable iff (!rst_n)
      !s_r.function_enable_bit && !reg_wr && !$past(reg_wr) && s_r.stat[5:0] == 6'h0 |=> s_r.stat[5:0] == 6'h0)
      else $error("endpoint event while disabled");
   a_frame_upd: assert property (@(posedge clk) disable iff (!rst_n)
      sof_end |=> s_r.frame == $past(sof_frame)) else $error("frame count not updated");
   a_rd_data: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == `UDSC_OFF_IMASK |=> reg_rdata[13:0] == $past(s_r.mask))
      else $error("mask readback wrong");

   // software acknowledge of a raised suspend flag, away from reset and resume
   sequence susp_ack_seq;
      reg_wr && reg_addr == `UDSC_OFF_ICLR && reg_wdata[`UDSC_BIT_SUSP] && s_r.stat[`UDSC_BIT_SUSP] &&
         s_r.pullup_on_bit && !bus_reset_end && !bus_activity &&
         s_r.st != UDSC_ST_ATTACHED && s_r.st != UDSC_ST_SUSPENDED;
   endsequence
   // pull-up switched on from the attached state
   sequence pullup_req_seq;
      reg_wr && reg_addr == `UDSC_OFF_TXVC && reg_wdata[`UDSC_TXVC_PULLUP_ON_BIT] && s_r.st == UDSC_ST_ATTACHED &&
         !bus_reset_end;
   endsequence
   // bus activity seen while still suspended
   sequence host_resume_seq;
      s_r.st == UDSC_ST_SUSPENDED && bus_activity;
   endsequence
   a_susp_enter: assert property (@(posedge clk) disable iff (!rst_n)
      susp_ack_seq |=> device_state == UDSC_ST_SUSPENDED)
      else $error("suspend state not entered");
   a_pullup_pwr: assert property (@(posedge clk) disable iff (!rst_n)
      pullup_req_seq |=> pullup_on && device_state == UDSC_ST_POWERED)
      else $error("pull-up did not power the device");
   a_resume_exit: assert property (@(posedge clk) disable iff (!rst_n)
      host_resume_seq |=> device_state != UDSC_ST_SUSPENDED)
      else $error("host resume not accepted");
   a_iclr_drop: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == `UDSC_OFF_ICLR && reg_wdata[`UDSC_BIT_SUSP] && !bus_idle_timeout |=>
      !s_r.stat[`UDSC_BIT_SUSP]) else $error("suspend flag not cleared");

   // bus reset end, interrupt line, read port and frame status bits
   a_busres_state: assert property (@(posedge clk) disable iff (!rst_n)
      bus_reset_end && s_r.pullup_on_bit && !(reg_wr && reg_addr == `UDSC_OFF_TXVC) |=> device_state == UDSC_ST_DEFAULT)
      else $error("bus reset end did not reach default state");
   a_addr_clear: assert property (@(posedge clk) disable iff (!rst_n)
      bus_reset_end |=> device_address == 7'h00 && !s_r.faddr_en && !s_r.confg)
      else $error("bus reset end kept the address state");
   a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
      irq == |(s_r.stat & (s_r.mask | (14'h1 << `UDSC_BIT_BUS_RESET_DONE_FLAG))))
      else $error("interrupt line does not follow status and mask");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside a read");
   a_frame_ok: assert property (@(posedge clk) disable iff (!rst_n)
      sof_end |=> s_r.frame_good_bit != $past(sof_error) && s_r.frame_error_bit == $past(sof_error))
      else $error("frame status bits wrong");
   a_sof_clear: assert property (@(posedge clk) disable iff (!rst_n)
      sof_start && !sof_end |=> !s_r.frame_good_bit && !s_r.frame_error_bit)
      else $error("frame status bits not cleared at sof");
   a_csr_rd: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == `UDSC_OFF_CSR_BASE |=> reg_rdata[15:0] == $past(s_r.csr[0]))
      else $error("endpoint control readback wrong");
endmodule

// [sim/udsc_host_model.sv]
// behavioural usb host side: bus reset, suspend, resume and start of frame
`timescale 1ns/1ns
module udsc_host_model (
   input wire logic clk,
   output logic bus_idle_timeout,
   output logic bus_reset_end,
   output logic bus_activity,
   output logic sof_start,
   output logic sof_end,
   output logic sof_error,
   output logic [10:0] sof_frame
);
   initial begin
      {bus_idle_timeout, bus_reset_end, bus_activity, sof_start, sof_end, sof_error} = 6'h00;
      sof_frame = 11'h000;
   end
   task automatic idle_gap();
      @(posedge clk);
      bus_idle_timeout <= 1'b1;
      @(posedge clk);
      bus_idle_timeout <= 1'b0;
   endtask
   task automatic bus_reset();
      @(posedge clk);
      bus_reset_end <= 1'b1;
      @(posedge clk);
      bus_reset_end <= 1'b0;
   endtask
   // resume edge lands between clock edges, as on a stopped port
   task automatic resume_edge();
      @(posedge clk);
      #3 bus_activity = 1'b1;
      #8 bus_activity = 1'b0;
   endtask
   task automatic frame(input logic [10:0] f, input logic e);
      @(posedge clk);
      sof_start <= 1'b1;
      @(posedge clk);
      sof_start <= 1'b0;
      sof_end <= 1'b1;
      sof_frame <= f;
      sof_error <= e;
      @(posedge clk);
      sof_end <= 1'b0;
      // stale frame data is not held, so a late capture shows up
      sof_frame <= ~f;
      sof_error <= ~e;
   endtask
endmodule

// [sim/udsc_top_tb_top.sv]
// self-checking bench for the usb device state control block
`timescale 1ns/1ns
`include "udsc_regs.svh"
module udsc_top_tb_top import udsc_pkg::*;;
   logic clk, rst_n, reg_wr, reg_rd, irq, pullup_on, transceiver_off, function_enabled, ext_resume;
   logic bus_idle_timeout, bus_reset_end, bus_activity, sof_start, sof_end, sof_error;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, ep_fifo_rdata, rv, seed, d;
   logic [10:0] sof_frame;
   logic [6:0] device_address;
   logic [2:0] device_state;
   logic [5:0] ep_event, ep_enabled, en_exp;
   int n_fail, compares;
   udsc_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_idle_timeout(bus_idle_timeout),
      .bus_reset_end(bus_reset_end), .bus_activity(bus_activity), .sof_start(sof_start), .sof_end(sof_end),
      .sof_error(sof_error), .sof_frame(sof_frame), .ext_resume(ext_resume), .ep_event(ep_event),
      .ep_fifo_rdata(ep_fifo_rdata), .irq(irq), .pullup_on(pullup_on), .transceiver_off(transceiver_off),
      .function_enabled(function_enabled), .device_address(device_address), .device_state(device_state),
      .ep_enabled(ep_enabled));
   udsc_host_model i_host (.clk(clk), .bus_idle_timeout(bus_idle_timeout), .bus_reset_end(bus_reset_end),
      .bus_activity(bus_activity), .sof_start(sof_start), .sof_end(sof_end), .sof_error(sof_error),
      .sof_frame(sof_frame));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] frame_exp(input logic [10:0] f, input logic e);
      return {14'h0000, ~e, e, 5'h00, f};
   endfunction
   task automatic close_out();
      if (n_fail == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic ep_pulse();
      @(posedge clk);
      ep_event <= 6'h3f;
      @(posedge clk);
      ep_event <= 6'h00;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // generous bound: the sequence needs well under a thousand cycles
   initial begin
      #20000;
      n_fail++;
      close_out();
   end
   initial begin
      rst_n = 1'b0;
      {reg_wr, reg_rd, ext_resume} = 3'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      ep_event = 6'h00;
      ep_fifo_rdata = 32'h0;
      seed = 32'h0000_4e33;
      n_fail = 0;
      compares = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rchk(`UDSC_OFF_FRAME, 32'h0);
      rchk(`UDSC_OFF_GLB, 32'h0);
      rchk(`UDSC_OFF_FADDR, `UDSC_FADDR_RESET);
      rchk(`UDSC_OFF_IMASK, 32'h0000_1200);
      rchk(`UDSC_OFF_EPRST, 32'h0);
      rchk(`UDSC_OFF_TXVC, 32'h0);
      rchk(8'h0c, 32'h0);
      for (int i = 0; i < 6; i++) rchk(`UDSC_OFF_CSR_BASE + 8'(4 * i), 32'h0);
      wr(`UDSC_OFF_TXVC, 32'h0000_0200);
      cyc(3);
      chk(pullup_on, 1'b1);
      chk(device_state, UDSC_ST_POWERED);
      wr(`UDSC_OFF_TXVC, 32'h0000_0300);
      cyc(2);
      chk(transceiver_off, 1'b1);
      wr(`UDSC_OFF_ICLR, 32'h0000_3fff);
      wr(`UDSC_OFF_IDIS, 32'h0000_3fff);
      wr(`UDSC_OFF_CSR_BASE + 8'h04, 32'h0000_8005);
      rchk(`UDSC_OFF_IMASK, 32'h0);
      chk(irq, 1'b0);
      i_host.bus_reset();
      cyc(3);
      chk(irq, 1'b1);
      rd(`UDSC_OFF_ISTAT);
      chk(rv & 32'h1000, 32'h1000);
      chk(device_state, UDSC_ST_DEFAULT);
      rchk(`UDSC_OFF_IMASK, 32'h0000_1200);
      rchk(`UDSC_OFF_CSR_BASE + 8'h04, 32'h0);
      wr(`UDSC_OFF_ICLR, 32'h0000_1000);
      cyc(3);
      chk(irq, 1'b0);
      wr(`UDSC_OFF_CSR_BASE, 32'h0000_8000);
      wr(`UDSC_OFF_TXVC, 32'h0000_0200);
      cyc(2);
      chk(ep_enabled[0], 1'b1);
      chk(transceiver_off, 1'b0);
      wr(`UDSC_OFF_FADDR, 32'h0);
      ep_pulse();
      cyc(2);
      rd(`UDSC_OFF_ISTAT);
      chk(rv & 32'h3f, 32'h0);
      d = rnd() & 32'h7f;
      wr(`UDSC_OFF_GLB, 32'h1);
      // status stage of the address request is over and its completion flag cleared
      wr(`UDSC_OFF_FADDR, 32'h100 | d);
      ep_pulse();
      cyc(3);
      chk(device_state, UDSC_ST_ADDRESS);
      chk(device_address, d[6:0]);
      chk(function_enabled, 1'b1);
      rd(`UDSC_OFF_ISTAT);
      chk(rv & 32'h3f, 32'h3f);
      wr(`UDSC_OFF_GLB, 32'h3);
      en_exp = 6'h01;
      for (int i = 1; i < 6; i++) begin
         d = rnd();
         en_exp[i] = d[15];
         wr(`UDSC_OFF_CSR_BASE + 8'(4 * i), d);
         rchk(`UDSC_OFF_CSR_BASE + 8'(4 * i), {16'h0000, d[15:0]});
         @(posedge clk);
         ep_fifo_rdata <= rnd();
         @(posedge clk);
         rchk(`UDSC_OFF_FDR_BASE + 8'(4 * i), ep_fifo_rdata);
      end
      chk(ep_enabled, en_exp);
      chk(device_state, UDSC_ST_CONFIGURED);
      for (int i = 0; i < 8; i++) begin
         d = rnd();
         i_host.frame(d[10:0], d[20]);
         cyc(2);
         rchk(`UDSC_OFF_FRAME, frame_exp(d[10:0], d[20]));
      end
      @(posedge clk);
      // remote wake request only; the board drives the K state, its ms timing is not modelled
      ext_resume <= 1'b1;
      @(posedge clk);
      ext_resume <= 1'b0;
      cyc(2);
      rd(`UDSC_OFF_ISTAT);
      chk(rv & 32'h0c00, 32'h0c00);
      rchk(`UDSC_OFF_GLB, 32'h0000_000b);
      wr(`UDSC_OFF_ICLR, 32'h0000_3fff);
      wr(`UDSC_OFF_IDIS, 32'h0000_0200);
      i_host.idle_gap();
      cyc(3);
      rd(`UDSC_OFF_ISTAT);
      chk(rv & 32'h100, 32'h100);
      chk(irq, 1'b0);
      wr(`UDSC_OFF_IEN, 32'h0000_0100);
      cyc(3);
      chk(irq, 1'b1);
      wr(`UDSC_OFF_TXVC, 32'h0000_0300);
      wr(`UDSC_OFF_ICLR, 32'h0000_0100);
      cyc(3);
      chk(device_state, UDSC_ST_SUSPENDED);
      chk(irq, 1'b0);
      i_host.resume_edge();
      cyc(6);
      chk(irq, 1'b0);
      chk(pullup_on, 1'b1);
      chk(device_state, UDSC_ST_CONFIGURED);
      rd(`UDSC_OFF_ISTAT);
      chk(rv & 32'h2200, 32'h2200);
      wr(`UDSC_OFF_IEN, 32'h0000_2000);
      cyc(3);
      chk(irq, 1'b1);
      wr(`UDSC_OFF_ICLR, 32'h0000_2000);
      wr(`UDSC_OFF_TXVC, 32'h0000_0200);
      cyc(3);
      chk(irq, 1'b0);
      chk(transceiver_off, 1'b0);
      wr(8'h0c, rnd());
      wr(`UDSC_OFF_IMASK, 32'h0);
      rchk(8'h0c, 32'h0);
      rchk(`UDSC_OFF_IMASK, 32'h0000_3100);
      d = rnd();
      wr(`UDSC_OFF_EPRST, d);
      rchk(`UDSC_OFF_EPRST, {26'h0, d[5:0]});
      close_out();
   end
endmodule
